// *** hdl/ao_current_pkg.sv ***
package ao_current_pkg;

  // ==========================================================
  // Geometry
  localparam int              NUM_CH          = 4;
  localparam int              IMG_AW          = 3;
  localparam int              PAR_AW          = 3;
  localparam logic [2:0]      PAR_CODE_FIRST  = 3'h2;
  localparam logic [2:0]      PAR_CODE_LAST   = 3'h5;
  localparam logic [7:0]      PAR_RSVD_VALUE  = 8'h00;

  // ==========================================================
  // Function codes
  localparam logic [7:0]      FN_KEEP         = 8'h00;
  localparam logic [7:0]      FN_K16_4_20     = 8'h04;
  localparam logic [7:0]      FN_K16_0_20     = 8'h06;
  localparam logic [7:0]      FN_K27_4_20     = 8'h0c;
  localparam logic [7:0]      FN_K27_0_20     = 8'h0e;
  localparam logic [7:0]      FN_OFF          = 8'hff;
  localparam logic [7:0]      FN_DEFAULT      = FN_K27_0_20;

  // ==========================================================
  // Code limits and rated full scale
  localparam logic signed [15:0] K16_OVER     = 16'sh5000;
  localparam logic signed [15:0] K16_UNDER    = 16'shf000;
  localparam logic signed [15:0] K16_FULL     = 16'sh4000;
  localparam logic signed [15:0] K27_OVER     = 16'sh7eff;
  localparam logic signed [15:0] K27_UNDER    = 16'she500;
  localparam logic signed [15:0] K27_FULL     = 16'sh6c00;
  localparam logic signed [15:0] CODE_ZERO    = 16'sh0000;

  // ==========================================================
  // Scaling to microamps, Q16 slopes
  localparam int              FRAC_BITS       = 16;
  localparam int              PROD_W          = 35;
  localparam logic [17:0]     SCALE_K16_4_20  = 18'h0fa00;
  localparam logic [17:0]     SCALE_K16_0_20  = 18'h13880;
  localparam logic [17:0]     SCALE_K27_4_20  = 18'h09426;
  localparam logic [17:0]     SCALE_K27_0_20  = 18'h0b92f;
  localparam logic signed [PROD_W-1:0] ROUND_HALF = 35'sh000008000;
  localparam logic [15:0]     LIVE_ZERO_UA    = 16'h0fa0;
  localparam logic [15:0]     FULL_UA         = 16'h4e20;
  localparam logic [15:0]     K16_0_20_OVER_UA = 16'h61a8;
  localparam logic [15:0]     UA_ZERO         = 16'h0000;

  // ==========================================================
  // Timing
  localparam int              CLK_MHZ         = 40;
  localparam int              UPDATE_CYCLE_US = 700;
  localparam int              UPDATE_CYCLES_DEF = UPDATE_CYCLE_US * CLK_MHZ;
  localparam int              CNT_W           = 15;

  typedef enum logic [0:0] {ST_NV_LOAD, ST_RUN} run_state_t;

endpackage

// *** hdl/conv_if.sv ***
`timescale 1ns/1ps
interface conv_if;
  logic        [7:0]  code;
  logic signed [15:0] value;
  logic        [15:0] current_ua;
  logic               active;

  modport ctrl (output code, output value, input current_ua, input active);
  modport conv (input code, input value, output current_ua, output active);
endinterface

// *** hdl/cur_channel_conv.sv ***
`timescale 1ns/1ps
module cur_channel_conv
  import ao_current_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic reset_n_i,
  input  wire logic ce_i,
  conv_if.conv      ch
);

  typedef struct packed {
    logic [15:0] current_ua;
    logic        active;
  } conv_state_t;

  conv_state_t st_reg;
  conv_state_t st_next;

  logic                     in_range;
  logic [17:0]              scale;
  logic [15:0]              offset;
  logic signed [PROD_W-1:0] prod;
  logic signed [18:0]       ua_wide;

  // ==========================================================
  // Code to current mapping
  always_comb begin
    in_range = 1'b0;
    scale    = SCALE_K27_0_20;
    offset   = UA_ZERO;
    case (ch.code)
      FN_K16_4_20: begin
        in_range = (ch.value >= K16_UNDER) && (ch.value <= K16_OVER);
        scale    = SCALE_K16_4_20;
        offset   = LIVE_ZERO_UA;
      end
      FN_K16_0_20: begin
        in_range = (ch.value >= CODE_ZERO) && (ch.value <= K16_OVER);
        scale    = SCALE_K16_0_20;
      end
      FN_K27_4_20: begin
        in_range = (ch.value >= K27_UNDER) && (ch.value <= K27_OVER);
        scale    = SCALE_K27_4_20;
        offset   = LIVE_ZERO_UA;
      end
      FN_K27_0_20: begin
        in_range = (ch.value >= CODE_ZERO) && (ch.value <= K27_OVER);
        scale    = SCALE_K27_0_20;
      end
      default: begin
        in_range = 1'b0;
      end
    endcase
    prod    = ch.value * $signed({1'b0, scale}) + ROUND_HALF;
    ua_wide = prod[PROD_W-1:FRAC_BITS] + $signed({3'b000, offset});
    st_next = st_reg;
    if (ce_i) begin
      st_next.active = in_range || ((ch.code != FN_OFF) && (ch.code != FN_KEEP));
      if (!in_range || ua_wide[18]) begin
        st_next.current_ua = UA_ZERO;
      end else begin
        st_next.current_ua = ua_wide[15:0];
      end
      if (ch.code == FN_OFF) begin
        st_next.active = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      st_reg <= '{current_ua: UA_ZERO, active: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign ch.current_ua = st_reg.current_ua;
  assign ch.active     = st_reg.active;

  // ==========================================================
  // Checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_OFF_ZERO: assert property (
    $past(reset_n_i) && $past(ce_i) && $past(ch.code) == FN_OFF
      |-> ch.current_ua == UA_ZERO && !ch.active)
    else $error("switched-off channel drives current");
  AST_OVER_ZERO: assert property (
    $past(reset_n_i) && $past(ce_i) && $past(ch.value) > K27_OVER
      |-> ch.current_ua == UA_ZERO)
    else $error("over-range code not forced to zero");
  AST_K16_4_20_FULL: assert property (
    $past(reset_n_i) && $past(ce_i) && $past(ch.code) == FN_K16_4_20
      && $past(ch.value) == K16_FULL |-> ch.current_ua == FULL_UA)
    else $error("4-20 mA 16k full scale wrong");
  AST_K16_0_20_OVER: assert property (
    $past(reset_n_i) && $past(ce_i) && $past(ch.code) == FN_K16_0_20
      && $past(ch.value) == K16_OVER |-> ch.current_ua == K16_0_20_OVER_UA)
    else $error("0-20 mA 16k over-range point wrong");
  AST_K27_4_20_UNDER: assert property (
    $past(reset_n_i) && $past(ce_i) && $past(ch.code) == FN_K27_4_20
      && $past(ch.value) == K27_UNDER |-> ch.current_ua == UA_ZERO)
    else $error("4-20 mA 27k under-range point wrong");
  AST_K27_0_20_FULL: assert property (
    $past(reset_n_i) && $past(ce_i) && $past(ch.code) == FN_K27_0_20
      && $past(ch.value) == K27_FULL |-> ch.current_ua == FULL_UA)
    else $error("0-20 mA 27k full scale wrong");

endmodule

// *** hdl/ao_current_ctrl.sv ***
`timescale 1ns/1ps
module ao_current_ctrl
  import ao_current_pkg::*;
#(
  parameter int UPDATE_CYCLES = UPDATE_CYCLES_DEF
) (
  input  wire logic                    core_clk_i,
  input  wire logic                    reset_n_i,
  input  wire logic                    ce_i,
  input  wire logic                    img_wr_i,
  input  wire logic [IMG_AW-1:0]       img_addr_i,
  input  wire logic [7:0]              img_data_i,
  input  wire logic                    par_wr_i,
  input  wire logic                    par_rd_i,
  input  wire logic [PAR_AW-1:0]       par_addr_i,
  input  wire logic [7:0]              par_wdata_i,
  output      logic [7:0]              par_rdata_o,
  input  wire logic                    nv_valid_i,
  input  wire logic [NUM_CH*8-1:0]     nv_image_i,
  output      logic                    nv_write_o,
  output      logic [NUM_CH*8-1:0]     nv_image_o,
  output      logic [NUM_CH-1:0][15:0] ch_current_ua_o,
  output      logic [NUM_CH-1:0]       ch_active_o,
  output      logic                    update_stb_o
);

  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(UPDATE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE  = 15'h0001;

  // Over-range end points of the output, in microamps
  localparam logic [15:0] K16_4_20_OVER_UA = 16'h5dc0;
  localparam logic [15:0] K27_4_20_OVER_UA = 16'h591e;
  localparam logic [15:0] K27_0_20_OVER_UA = 16'h5bde;

  // ==========================================================
  // State
  typedef struct packed {
    run_state_t              state;
    logic [NUM_CH-1:0][15:0] image;
    logic [NUM_CH-1:0][15:0] applied;
    logic [NUM_CH-1:0][7:0]  codes;
    logic [CNT_W-1:0]        cycle_cnt;
    logic                    update_stb;
    logic                    nv_write;
    logic [7:0]              par_rdata;
  } ctl_state_t;

  localparam ctl_state_t RST_STATE = '{
    state:      ST_NV_LOAD,
    image:      '0,
    applied:    '0,
    codes:      {NUM_CH{FN_DEFAULT}},
    cycle_cnt:  '0,
    update_stb: 1'b0,
    nv_write:   1'b0,
    par_rdata:  PAR_RSVD_VALUE
  };

  ctl_state_t st_reg;
  ctl_state_t st_next;

  // Only codes that select a real mode may be stored
  function automatic logic code_ok(input logic [7:0] code);
    logic ok;
    case (code)
      FN_K16_4_20: ok = 1'b1;
      FN_K16_0_20: ok = 1'b1;
      FN_K27_4_20: ok = 1'b1;
      FN_K27_0_20: ok = 1'b1;
      FN_OFF:     ok = 1'b1;
      default:    ok = 1'b0;
    endcase
    return ok;
  endfunction

  logic             par_is_code;
  logic [1:0]       par_idx;
  logic [1:0]       img_ch;

  assign par_is_code = (par_addr_i >= PAR_CODE_FIRST) && (par_addr_i <= PAR_CODE_LAST);
  assign par_idx     = 2'(par_addr_i - PAR_CODE_FIRST);
  assign img_ch      = img_addr_i[IMG_AW-1:1];

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    if (ce_i) begin
      st_next.update_stb = 1'b0;
      st_next.nv_write   = 1'b0;

      case (st_reg.state)
        ST_NV_LOAD: begin
          if (nv_valid_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
              if (code_ok(nv_image_i[i*8 +: 8])) begin
                st_next.codes[i] = nv_image_i[i*8 +: 8];
              end
            end
            st_next.state = ST_RUN;
          end
        end
        ST_RUN: begin
          // Reserved bytes, 00h and unknown codes fall through untouched
          if (par_wr_i && par_is_code && code_ok(par_wdata_i)) begin
            if (par_wdata_i != st_reg.codes[par_idx]) begin
              st_next.codes[par_idx] = par_wdata_i;
              st_next.nv_write       = 1'b1;
            end
          end
        end
        default: begin
          st_next.state = ST_NV_LOAD;
        end
      endcase

      // Big-endian byte pairs in the output image
      if (img_wr_i) begin
        if (!img_addr_i[0]) begin
          st_next.image[img_ch][15:8] = img_data_i;
        end else begin
          st_next.image[img_ch][7:0]  = img_data_i;
        end
      end

      if (par_rd_i) begin
        if (par_is_code) begin
          st_next.par_rdata = st_reg.codes[par_idx];
        end else begin
          st_next.par_rdata = PAR_RSVD_VALUE;
        end
      end

      // Update cycle: all channels take a fresh snapshot together
      if (st_reg.cycle_cnt >= CNT_LAST) begin
        st_next.cycle_cnt  = '0;
        st_next.applied    = st_reg.image;
        st_next.update_stb = 1'b1;
      end else begin
        st_next.cycle_cnt  = st_reg.cycle_cnt + CNT_ONE;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      st_reg <= RST_STATE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Channel converters
  conv_if cif [NUM_CH] ();

  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      assign cif[g].code       = st_reg.codes[g];
      assign cif[g].value      = $signed(st_reg.applied[g]);
      assign ch_current_ua_o[g] = cif[g].current_ua;
      assign ch_active_o[g]     = cif[g].active;

      cur_channel_conv u_conv (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .ce_i       (ce_i),
        .ch         (cif[g].conv)
      );
    end
  endgenerate

  // ==========================================================
  // Outputs
  assign par_rdata_o  = st_reg.par_rdata;
  assign nv_write_o   = st_reg.nv_write;
  assign nv_image_o   = st_reg.codes;
  assign update_stb_o = st_reg.update_stb;

  // ==========================================================
  // Checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_RSVD_IGNORED: assert property (
    ce_i && st_reg.state == ST_RUN && par_wr_i && par_addr_i < PAR_CODE_FIRST
      |=> $stable(st_reg.codes))
    else $error("reserved parameter write changed a code");

  AST_KEEP_CODE: assert property (
    ce_i && st_reg.state == ST_RUN && par_wr_i && par_wdata_i == FN_KEEP
      |=> $stable(st_reg.codes))
    else $error("code 00h changed a stored code");

  AST_BAD_CODE: assert property (
    ce_i && st_reg.state == ST_RUN && par_wr_i && !code_ok(par_wdata_i)
      |=> $stable(st_reg.codes) && !nv_write_o)
    else $error("undefined code was stored");

  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
      AST_CODE_TAKEN: assert property (
        ce_i && st_reg.state == ST_RUN && par_wr_i
          && par_addr_i == PAR_CODE_FIRST + 3'(g) && code_ok(par_wdata_i)
          |=> st_reg.codes[g] == $past(par_wdata_i))
        else $error("channel code write not taken");

      AST_BYTE_ORDER: assert property (
        ce_i && img_wr_i && img_addr_i == {2'(g), 1'b0}
          |=> st_reg.image[g][15:8] == $past(img_data_i))
        else $error("high byte landed in the wrong place");

      AST_OUT_OFF: assert property (
        ce_i && st_reg.codes[g] == FN_OFF
          |=> ch_current_ua_o[g] == UA_ZERO && !ch_active_o[g])
        else $error("switched-off channel output not idle");

      AST_OUT_ACTIVE: assert property (
        ce_i && st_reg.codes[g] != FN_OFF |=> ch_active_o[g])
        else $error("configured channel not active");

      AST_OUT_UNDER: assert property (
        ce_i && (st_reg.codes[g] == FN_K16_0_20 || st_reg.codes[g] == FN_K27_0_20)
          && $signed(st_reg.applied[g]) < CODE_ZERO |=> ch_current_ua_o[g] == UA_ZERO)
        else $error("under-range code not forced to zero");

      AST_OUT_K16_4_20_TOP: assert property (
        ce_i && st_reg.codes[g] == FN_K16_4_20 && st_reg.applied[g] == K16_OVER
          |=> ch_current_ua_o[g] == K16_4_20_OVER_UA)
        else $error("4-20 mA 16k over-range point wrong");

      AST_OUT_K27_4_20_TOP: assert property (
        ce_i && st_reg.codes[g] == FN_K27_4_20 && st_reg.applied[g] == K27_OVER
          |=> ch_current_ua_o[g] == K27_4_20_OVER_UA)
        else $error("4-20 mA 27k over-range point wrong");

      AST_OUT_K27_0_20_TOP: assert property (
        ce_i && st_reg.codes[g] == FN_K27_0_20 && st_reg.applied[g] == K27_OVER
          |=> ch_current_ua_o[g] == K27_0_20_OVER_UA)
        else $error("0-20 mA 27k over-range point wrong");
    end
  endgenerate

  AST_APPLY_AT_WRAP: assert property (
    ce_i && st_reg.cycle_cnt == CNT_LAST
      |=> st_reg.applied == $past(st_reg.image) && update_stb_o)
    else $error("update cycle did not refresh all channels");

  AST_APPLIED_HOLD: assert property (
    $past(reset_n_i) && !($past(ce_i) && $past(st_reg.cycle_cnt) == CNT_LAST)
      |-> $stable(st_reg.applied) && !update_stb_o || !$past(ce_i))
    else $error("outputs changed between update cycles");

  AST_CNT_BOUND: assert property (
    st_reg.cycle_cnt <= CNT_LAST)
    else $error("update counter ran past the cycle length");

  AST_DEFAULT_CODE: assert property (
    !$past(reset_n_i) |-> st_reg.codes == {NUM_CH{FN_DEFAULT}}
      && st_reg.state == ST_NV_LOAD)
    else $error("codes not at default after reset");

  AST_NV_COMMIT: assert property (
    nv_write_o && $past(ce_i) |-> st_reg.codes != $past(st_reg.codes)
      && nv_image_o == st_reg.codes)
    else $error("non-volatile commit without a code change");

  AST_FREEZE: assert property (
    !ce_i |=> $stable(st_reg))
    else $error("state moved while clock enable low");

  COV_UPDATE:    cover property (update_stb_o ##1 !update_stb_o);
  COV_CODE_WR:   cover property (nv_write_o);
  COV_NV_LOAD:   cover property (st_reg.state == ST_NV_LOAD ##1 st_reg.state == ST_RUN);
  COV_CH_OFF:    cover property (st_reg.codes[0] == FN_OFF && !ch_active_o[0]);
  COV_FROZEN:    cover property (!ce_i ##1 !ce_i);

endmodule

// *** tb/cpu_model.sv ***
`timescale 1ns/1ps
module cpu_model
  import ao_current_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic [7:0]        par_rdata_i,
  input  wire logic              nv_write_i,
  output      logic              img_wr_o,
  output      logic [IMG_AW-1:0] img_addr_o,
  output      logic [7:0]        img_data_o,
  output      logic              par_wr_o,
  output      logic              par_rd_o,
  output      logic [PAR_AW-1:0] par_addr_o,
  output      logic [7:0]        par_wdata_o
);
  initial begin
    img_wr_o    = 1'b0;
    img_addr_o  = 3'h0;
    img_data_o  = 8'h00;
    par_wr_o    = 1'b0;
    par_rd_o    = 1'b0;
    par_addr_o  = 3'h0;
    par_wdata_o = 8'h00;
  end

  // ==========================================================
  // Image burst: signed words, high byte at the even address
  task automatic img_burst(input logic [NUM_CH-1:0][15:0] val);
    for (int b = 0; b < 8; b++) begin
      @(negedge core_clk_i);
      img_wr_o   = 1'b1;
      img_addr_o = 3'(b);
      img_data_o = b[0] ? val[b/2][7:0] : val[b/2][15:8];
    end
    @(negedge core_clk_i);
    img_wr_o   = 1'b0;
    img_data_o = ~img_data_o;
  endtask

  // ==========================================================
  // Parameter byte access, released lines show the inverse
  task automatic par_write(input logic [2:0] a, input logic [7:0] d, output logic nv);
    @(negedge core_clk_i);
    par_wr_o    = 1'b1;
    par_addr_o  = a;
    par_wdata_o = d;
    @(negedge core_clk_i);
    par_wr_o    = 1'b0;
    par_wdata_o = ~d;
    nv          = nv_write_i;
  endtask

  task automatic par_read(input logic [2:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    par_rd_o   = 1'b1;
    par_addr_o = a;
    @(negedge core_clk_i);
    par_rd_o   = 1'b0;
    par_addr_o = ~a;
    d          = par_rdata_i;
  endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  import ao_current_pkg::*;
  localparam int UC = 16;

  logic                    core_clk_i = 1'b0;
  logic                    reset_n_i, ce_i, nv_valid_i;
  logic [31:0]             nv_image_i;
  logic                    img_wr_i, par_wr_i, par_rd_i, nv_write_o, update_stb_o;
  logic [2:0]              img_addr_i, par_addr_i;
  logic [7:0]              img_data_i, par_wdata_i, par_rdata_o;
  logic [31:0]             nv_image_o;
  logic [NUM_CH-1:0][15:0] ch_current_ua_o;
  logic [NUM_CH-1:0]       ch_active_o;
  logic [7:0]              codes [NUM_CH];
  logic [31:0]             seed = 32'h0000000e;
  int                      failures = 0;
  int                      n_tests = 0;

  always #12.5 core_clk_i = ~core_clk_i;

  ao_current_ctrl #(.UPDATE_CYCLES(UC)) u_ao_current_ctrl (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .img_wr_i(img_wr_i), .img_addr_i(img_addr_i), .img_data_i(img_data_i),
    .par_wr_i(par_wr_i), .par_rd_i(par_rd_i), .par_addr_i(par_addr_i),
    .par_wdata_i(par_wdata_i), .par_rdata_o(par_rdata_o), .nv_valid_i(nv_valid_i),
    .nv_image_i(nv_image_i), .nv_write_o(nv_write_o), .nv_image_o(nv_image_o),
    .ch_current_ua_o(ch_current_ua_o), .ch_active_o(ch_active_o),
    .update_stb_o(update_stb_o)
  );

  cpu_model u_cpu_model (
    .core_clk_i(core_clk_i), .par_rdata_i(par_rdata_o), .nv_write_i(nv_write_o),
    .img_wr_o(img_wr_i), .img_addr_o(img_addr_i), .img_data_o(img_data_i),
    .par_wr_o(par_wr_i), .par_rd_o(par_rd_i), .par_addr_o(par_addr_i),
    .par_wdata_o(par_wdata_i)
  );

  // ==========================================================
  // Expectations
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] next_code(logic [7:0] old, logic [7:0] d);
    return (d inside {FN_K16_4_20, FN_K16_0_20, FN_K27_4_20, FN_K27_0_20, FN_OFF}) ? d : old;
  endfunction

  function automatic logic [15:0] exp_ua(logic [7:0] code, logic signed [15:0] v);
    longint lo, hi, sl, off, r;
    case (code)
      FN_K16_4_20: begin
        lo  = K16_UNDER;
        hi  = K16_OVER;
        sl  = SCALE_K16_4_20;
        off = LIVE_ZERO_UA;
      end
      FN_K16_0_20: begin
        lo  = CODE_ZERO;
        hi  = K16_OVER;
        sl  = SCALE_K16_0_20;
        off = 0;
      end
      FN_K27_4_20: begin
        lo  = K27_UNDER;
        hi  = K27_OVER;
        sl  = SCALE_K27_4_20;
        off = LIVE_ZERO_UA;
      end
      FN_K27_0_20: begin
        lo  = CODE_ZERO;
        hi  = K27_OVER;
        sl  = SCALE_K27_0_20;
        off = 0;
      end
      default: return UA_ZERO;
    endcase
    if (longint'(v) < lo || longint'(v) > hi) return UA_ZERO;
    r = ((longint'(v) * sl + ROUND_HALF) >>> FRAC_BITS) + off;
    return (r < 0) ? UA_ZERO : r[15:0];
  endfunction

  // ==========================================================
  // Compares and verdict
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cur(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: current %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenario helpers
  task automatic check_codes();
    logic [7:0] rd;
    for (int a = 0; a < 8; a++) begin
      u_cpu_model.par_read(3'(a), rd);
      chk_byte(rd, (a >= 2 && a <= 5) ? codes[a-2] : PAR_RSVD_VALUE);
    end
    for (int c = 0; c < NUM_CH; c++) chk_byte(nv_image_o[8*c+:8], codes[c]);
  endtask

  task automatic run_conv(input logic [NUM_CH-1:0][7:0] cd,
                          input logic [NUM_CH-1:0][15:0] val);
    logic nv;
    int   n;
    for (int c = 0; c < NUM_CH; c++) begin
      u_cpu_model.par_write(3'(c + 2), cd[c], nv);
      codes[c] = cd[c];
    end
    u_cpu_model.img_burst(val);
    n = 0;
    do begin
      @(negedge core_clk_i);
      n++;
      if (n > UC) begin
        failures++;
        $display("unexpected at %0t: no refresh", $time);
        results();
      end
    end while (update_stb_o !== 1'b1);
    @(negedge core_clk_i);
    for (int c = 0; c < NUM_CH; c++) begin
      chk_cur(ch_current_ua_o[c], exp_ua(codes[c], val[c]));
      chk_bit(ch_active_o[c], codes[c] !== FN_OFF);
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [NUM_CH-1:0][7:0]  cd;
    logic [NUM_CH-1:0][15:0] val;
    logic [7:0]              d, rd;
    logic [31:0]             r;
    logic                    nv;
    logic [7:0]              wr_tab [7];
    logic [7:0]              modes [5];
    logic [15:0]             corner [12];
    wr_tab = '{8'h00, FN_K16_4_20, FN_K16_0_20, FN_K27_4_20, FN_OFF, 8'h07, FN_K27_0_20};
    modes  = '{FN_K16_4_20, FN_K16_0_20, FN_K27_4_20, FN_K27_0_20, FN_OFF};
    corner = '{16'h0000, 16'h4000, 16'h5000, 16'h5001, 16'hf000, 16'hefff,
               16'h6c00, 16'h7eff, 16'h7f00, 16'he500, 16'he4ff, 16'hffff};
    reset_n_i  = 1'b0;
    ce_i       = 1'b1;
    nv_valid_i = 1'b0;
    nv_image_i = 32'h0cff0004;
    for (int c = 0; c < NUM_CH; c++) codes[c] = FN_DEFAULT;
    repeat (16) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    u_cpu_model.par_write(3'h2, FN_K16_4_20, nv);
    chk_bit(nv, 1'b0);
    check_codes();
    nv_valid_i = 1'b1;
    @(negedge core_clk_i);
    codes = '{FN_K16_4_20, FN_DEFAULT, FN_OFF, FN_K27_4_20};
    check_codes();
    for (int a = 0; a < 8; a++) begin
      for (int k = 0; k < 8; k++) begin
        r = xs();
        d = (k < 7) ? wr_tab[k] : r[7:0];
        u_cpu_model.par_write(3'(a), d, nv);
        if (a >= 2 && a <= 5) begin
          chk_bit(nv, next_code(codes[a-2], d) !== codes[a-2]);
          codes[a-2] = next_code(codes[a-2], d);
        end else begin
          chk_bit(nv, 1'b0);
        end
        u_cpu_model.par_read(3'(a), rd);
        chk_byte(rd, (a >= 2 && a <= 5) ? codes[a-2] : PAR_RSVD_VALUE);
      end
    end
    for (int it = 0; it < 100; it++) begin
      for (int c = 0; c < NUM_CH; c++) begin
        r = xs();
        cd[c]  = (it < 60) ? modes[(it + c) % 5] : modes[r % 5];
        val[c] = (it < 60) ? corner[(it / 5 + c) % 12] : r[31:16];
      end
      run_conv(cd, val);
    end
    // Clock enable low: writes, counter, strobe and outputs stand still
    ce_i = 1'b0;
    d    = (codes[0] == FN_OFF) ? FN_K27_0_20 : FN_OFF;
    u_cpu_model.par_write(3'h2, d, nv);
    chk_bit(nv, 1'b0);
    for (int w = 0; w < 2 * UC; w++) begin
      @(negedge core_clk_i);
      chk_bit(update_stb_o, 1'b0);
      for (int c = 0; c < NUM_CH; c++) begin
        chk_cur(ch_current_ua_o[c], exp_ua(codes[c], val[c]));
      end
    end
    ce_i = 1'b1;
    nv_image_i = {codes[3], codes[2], codes[1], codes[0]};
    reset_n_i  = 1'b0;
    repeat (16) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    @(negedge core_clk_i);
    check_codes();
    results();
  end
endmodule
